// ===== dv/ddl_chain_model.sv
// Purpose: delay chain and phase sampler seen from the controller
// Assumes: target is the setting that brings the chain into phase
// Notes:   slow adds three cycles of sampler lag
`timescale 1ns/1ns
module ddl_chain_model (
  input  wire logic       clk,
  input  wire logic [5:0] dly,
  input  wire logic [6:0] target,
  input  wire logic       slow,
  output logic            chain_lead
);
  logic [5:0] bin;
  logic [3:0] lag_q;
  always_comb begin
    bin[5] = dly[5];
    for (int i = 4; i >= 0; i--)
      bin[i] = bin[i+1] ^ dly[i];
  end
  always_ff @(posedge clk)
    lag_q <= {lag_q[2:0], {1'b0, bin} < target};
  assign chain_lead = slow ? lag_q[3] : lag_q[0];
endmodule

// ===== dv/ddl_dll_ctrl_properties.sv
// Purpose: port assertions for the loop controller
// Assumes: cfg.mode only changes while a loop reset is held
// Notes:   q_q counts edges since the last reset of any kind
`timescale 1ns/1ns
module ddl_dll_ctrl_properties
  import ddl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        core_loop_rst,
  input wire logic        pin_loop_rst,
  input wire logic        chain_lead,
  input wire ddl_cfg_t    cfg,
  input wire logic [4:0]  chain_elems,
  input wire logic        ref_pin_sel,
  input wire logic [11:0] phase_tenths,
  input wire logic [5:0]  lvl_dly,
  input wire ddl_strobe_t strobe,
  input wire ddl_core_t   core
);
  logic [11:0] q_q;
  logic        quiet;
  // a loop reset in flight is never quiet, even before q_q clears
  assign quiet = (q_q > 12'h00C) && !core_loop_rst && !pin_loop_rst;
  always_ff @(posedge clk) begin
    if (!rst_n || core_loop_rst || pin_loop_rst)
      q_q <= 12'h000;
    else if (q_q != 12'hFFF)
      q_q <= q_q + 12'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_move;
    quiet && $changed(lvl_dly);
  endsequence
  property p_gray;
    s_move |-> $countones(lvl_dly ^ $past(lvl_dly)) == 1;
  endproperty
  a_gray: assert property (p_gray)
    else $error("delay setting moved more than one bit");
  property p_pace;
    disable iff (!rst_n || !quiet) s_move |=> $stable(lvl_dly)[*7];
  endproperty
  a_pace: assert property (p_pace)
    else $error("delay setting updated too soon");
  property p_msb;
    quiet && cfg.mode >= 3'h4 |-> !lvl_dly[5];
  endproperty
  a_msb: assert property (p_msb)
    else $error("top delay bit set in five bit mode");
  property p_fan;
    lvl_dly == core.dly && core.dly == strobe.dly;
  endproperty
  a_fan: assert property (p_fan)
    else $error("delay destinations disagree");
  property p_clr;
    core_loop_rst || pin_loop_rst |-> ##[1:6] !core.locked;
  endproperty
  a_clr: assert property (p_clr)
    else $error("lock flag kept through loop reset");
  property p_lock;
    $rose(core.locked) |-> q_q >= 12'h100;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag raised too early");
  property p_bypass;
    $past(rst_n) && $past(cfg.phase_zero) |-> strobe.bypass
      && phase_tenths == 12'h000 && strobe.chain_steps == 3'h0;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero shift not bypassed");
  property p_side;
    $past(rst_n) |-> core.resync_en == !$past(cfg.ioe_resync_used)
      && strobe.cqn_neg_en == $past(cfg.qdr_mode) && strobe.dq_clk_en
      && ref_pin_sel == $past(cfg.ref_from_pin);
  endproperty
  a_side: assert property (p_side)
    else $error("strobe routing flags wrong");
endmodule
bind ddl_dll_ctrl ddl_dll_ctrl_properties u_prop (
  .clk(clk), .rst_n(rst_n), .core_loop_rst(core_loop_rst),
  .pin_loop_rst(pin_loop_rst), .chain_lead(chain_lead), .cfg(cfg),
  .chain_elems(chain_elems), .ref_pin_sel(ref_pin_sel),
  .phase_tenths(phase_tenths), .lvl_dly(lvl_dly), .strobe(strobe),
  .core(core)
);

// ===== dv/ddl_dll_ctrl_tb_top.sv
// Purpose: self-checking bench for the loop controller
// Assumes: the chain model stands in for the analog sampler
// Notes:   lock time measured from loop reset release
`timescale 1ns/1ns
module ddl_dll_ctrl_tb_top
  import ddl_pkg::*;
();
  logic        clk, rst_n, core_loop_rst, pin_loop_rst, chain_lead, slow;
  ddl_cfg_t    cfg;
  logic [6:0]  target;
  logic [4:0]  chain_elems;
  logic        ref_pin_sel;
  logic [11:0] phase_tenths;
  logic [5:0]  lvl_dly;
  ddl_strobe_t strobe;
  ddl_core_t   core;
  int          n_fail, checked;
  logic [4:0]  el[8] = '{5'h10, 5'h0C, 5'h0A, 5'h08,
                          5'h0C, 5'h0A, 5'h08, 5'h06};
  logic [11:0] st[8] = '{12'h0E1, 12'h12C, 12'h168, 12'h1C2,
                          12'h12C, 12'h168, 12'h1C2, 12'h258};
  ddl_dll_ctrl u_dut (
    .clk(clk), .rst_n(rst_n), .core_loop_rst(core_loop_rst),
    .pin_loop_rst(pin_loop_rst), .chain_lead(chain_lead), .cfg(cfg),
    .chain_elems(chain_elems), .ref_pin_sel(ref_pin_sel),
    .phase_tenths(phase_tenths), .lvl_dly(lvl_dly), .strobe(strobe),
    .core(core)
  );
  ddl_chain_model u_far (
    .clk(clk), .dly(lvl_dly), .target(target), .slow(slow),
    .chain_lead(chain_lead)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [5:0] g2b(logic [5:0] g);
    for (int i = 4; i >= 0; i--)
      g[i] = g[i+1] ^ g[i];
    return g;
  endfunction
  task automatic restart(logic pin, logic [2:0] m, logic lj);
    @(posedge clk);
    cfg.mode <= m;
    cfg.low_jitter <= lj;
    core_loop_rst <= !pin;
    pin_loop_rst <= pin;
    repeat (4) @(posedge clk);
    core_loop_rst <= 1'b0;
    pin_loop_rst <= 1'b0;
  endtask
  task automatic t_lock(logic pin, logic lj);
    int n;
    int lim;
    restart(pin, 3'h0, lj);
    lim = lj ? 1280 : 256;
    n = 0;
    while (core.locked !== 1'b1 && n < 1400) begin
      @(posedge clk);
      n++;
    end
    chk("lock_time", 1'b1, n >= lim && n <= lim + 8);
    if (n >= 1400)
      tally_and_finish();
    chk("lock_track", 1'b1, g2b(lvl_dly) inside {[18:21]});
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      restart(1'b0, m[2:0], 1'b0);
      for (int k = 0; k < 4; k++) begin
        cfg.phase_mult <= k[1:0];
        repeat (3) @(posedge clk);
        chk("elems", el[m], chain_elems);
        chk("tenths", st[m] * (k + 1), phase_tenths);
        chk("steps", k + 1, strobe.chain_steps);
      end
    end
  endtask
  task automatic t_misc();
    cfg.offset_mag <= 6'h2A;
    cfg.offset_sub <= 1'b1;
    cfg.phase_zero <= 1'b1;
    cfg.qdr_mode <= 1'b1;
    cfg.ioe_resync_used <= 1'b1;
    cfg.ref_from_pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk("bypass", 1'b1, strobe.bypass);
    chk("off_mask", 6'h00, strobe.offset_mag);
    chk("resync", 1'b0, core.resync_en);
    chk("dq_clk", 1'b1, strobe.dq_clk_en);
    chk("cqn_neg", 1'b1, strobe.cqn_neg_en);
    chk("ref_pin", 1'b1, ref_pin_sel);
    chk("zero_tenths", 12'h000, phase_tenths);
    chk("zero_steps", 3'h0, strobe.chain_steps);
    chk("off_en0", 1'b0, strobe.offset_en);
    chk("off_sub0", 1'b0, strobe.offset_sub);
    cfg.offset_en <= 1'b1;
    cfg.phase_zero <= 1'b0;
    repeat (3) @(posedge clk);
    chk("off_mag", 6'h2A, strobe.offset_mag);
    chk("off_sub", 1'b1, strobe.offset_sub);
  endtask
  task automatic t_sat(logic [2:0] m, logic [6:0] tgt, logic [5:0] exp);
    restart(1'b0, m, 1'b0);
    target <= tgt;
    repeat (700) @(posedge clk);
    chk("sat", exp, g2b(lvl_dly));
  endtask
  initial begin
    rst_n = 1'b0;
    core_loop_rst = 1'b0;
    pin_loop_rst = 1'b0;
    slow = 1'b0;
    cfg = '0;
    target = 7'h14;
    n_fail = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    chk("rst_dly", 6'h00, lvl_dly);
    rst_n <= 1'b1;
    t_lock(1'b0, 1'b0);
    slow <= 1'b1;
    t_lock(1'b1, 1'b1);
    t_modes();
    t_misc();
    t_sat(3'h0, 7'h46, 6'h3F);
    t_sat(3'h4, 7'h46, 6'h1F);
    t_sat(3'h1, 7'h00, 6'h00);
    tally_and_finish();
  end
endmodule

// ===== rtl/ddl_dll_ctrl.sv
// Purpose: delay-locked loop controller producing the strobe delay setting
// Assumes: clk is the selected reference clock; cfg is static core logic
// Notes:   mode and jitter choice are taken while the loop is in reset
`timescale 1ns/1ns
module ddl_dll_ctrl
  import ddl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        core_loop_rst,
  input  wire logic        pin_loop_rst,
  input  wire logic        chain_lead,
  input  wire ddl_cfg_t    cfg,
  output logic      [4:0]  chain_elems,
  output logic             ref_pin_sel,
  output logic      [11:0] phase_tenths,
  output logic      [5:0]  lvl_dly,
  output ddl_strobe_t      strobe,
  output ddl_core_t        core
);

  typedef struct packed {
    ddl_state_t  st;
    logic        pin_s1;
    logic        pin_s2;
    logic [10:0] lock_cnt;
    logic [2:0]  mode;
    logic        low_jitter;
    logic [4:0]  chain_elems;
    logic        ref_pin_sel;
    logic [11:0] phase_tenths;
    logic [5:0]  lvl_dly;
    ddl_strobe_t strobe;
    ddl_core_t   core;
  } ddl_top_state_t;

  ddl_top_state_t s_q;
  ddl_top_state_t s_d;

  logic        loop_rst;
  logic        cnt_clear;
  logic        upd;
  logic        up;
  logic [5:0]  dly_gray;
  logic [10:0] lock_target;
  logic [2:0]  mult;

  // loop reset from core logic or synchronised pin
  assign loop_rst  = core_loop_rst | s_q.pin_s2;
  assign cnt_clear = loop_rst | (s_q.st == ST_RESET);

  ddl_phase_detect u_pd (
    .clk        (clk),
    .rst_n      (rst_n),
    .clear      (cnt_clear),
    .chain_lead (chain_lead),
    .upd        (upd),
    .up         (up)
  );

  ddl_gray_counter u_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (cnt_clear),
    .step  (upd),
    .up    (up),
    .half  (ddl_half_mode(s_q.mode)),
    .gray  (dly_gray)
  );

  always_comb begin
    s_d        = s_q;
    s_d.pin_s1 = pin_loop_rst;
    s_d.pin_s2 = s_q.pin_s1;
    lock_target = s_q.low_jitter ? LOCK_CYC_LJ : LOCK_CYC_STD;
    mult = {1'b0, cfg.phase_mult} + 3'h1;

    case (s_q.st)
      ST_RESET: begin
        s_d.mode       = cfg.mode;
        s_d.low_jitter = cfg.low_jitter;
        s_d.lock_cnt   = 11'h000;
        if (!loop_rst) begin
          s_d.st = ST_LOCKING;
        end
      end
      ST_LOCKING: begin
        s_d.lock_cnt = s_q.lock_cnt + 11'h001;
        if (s_q.lock_cnt == lock_target - 11'h001) begin
          s_d.st = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        s_d.st = ST_LOCKED;
      end
      default: begin
        s_d.st = ST_RESET;
      end
    endcase
    if (loop_rst) begin
      s_d.st       = ST_RESET;
      s_d.lock_cnt = 11'h000;
    end

    // chain length follows the active mode
    s_d.chain_elems = ddl_chain_elems(s_q.mode);
    s_d.ref_pin_sel = cfg.ref_from_pin;

    if (cfg.phase_zero) begin
      s_d.phase_tenths = 12'h000;
    end else begin
      s_d.phase_tenths = 12'(ddl_step_tenths(s_q.mode) * mult);
    end

    // one setting, three destinations
    s_d.core.dly   = dly_gray;
    s_d.lvl_dly    = dly_gray;
    s_d.strobe.dly = dly_gray;
    s_d.core.locked    = (s_d.st == ST_LOCKED);
    s_d.core.resync_en = !cfg.ioe_resync_used;

    // offset reaches strobe blocks only
    s_d.strobe.offset_en  = cfg.offset_en;
    s_d.strobe.offset_sub = cfg.offset_en & cfg.offset_sub;
    s_d.strobe.offset_mag = cfg.offset_en ? cfg.offset_mag : 6'h00;

    s_d.strobe.bypass      = cfg.phase_zero;
    s_d.strobe.chain_steps = cfg.phase_zero ? 3'h0 : mult;
    s_d.strobe.dq_clk_en   = 1'b1;
    s_d.strobe.cqn_neg_en  = cfg.qdr_mode;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q      <= '0;
      s_q.st   <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign chain_elems  = s_q.chain_elems;
  assign ref_pin_sel  = s_q.ref_pin_sel;
  assign phase_tenths = s_q.phase_tenths;
  assign lvl_dly      = s_q.lvl_dly;
  assign strobe       = s_q.strobe;
  assign core         = s_q.core;

endmodule

// ===== rtl/ddl_gray_counter.sv
// Purpose: saturating up/down counter with gray-coded registered output
// Assumes: step is a one-cycle pulse, clear held during loop reset
// Notes:   half limits the count to five bits
`timescale 1ns/1ns
module ddl_gray_counter
  import ddl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             step,
  input  wire logic             up,
  input  wire logic             half,
  output logic      [DLY_W-1:0] gray
);

  typedef struct packed {
    logic [DLY_W-1:0] bin;
    logic [DLY_W-1:0] gray;
  } ddl_gc_state_t;

  ddl_gc_state_t s_q;
  ddl_gc_state_t s_d;
  logic [DLY_W-1:0] lim;

  always_comb begin
    s_d = s_q;
    lim = half ? DLY_MAX_HALF : DLY_MAX_FULL;
    if (clear) begin
      s_d.bin = DLY_RST;
    end else if (step) begin
      if (up && s_q.bin < lim) begin
        s_d.bin = s_q.bin + 6'h01;
      end else if (!up && s_q.bin != 6'h00) begin
        s_d.bin = s_q.bin - 6'h01;
      end
    end
    if (s_d.bin > lim) begin
      s_d.bin = lim;
    end
    s_d.gray = s_d.bin ^ (s_d.bin >> 1);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign gray = s_q.gray;

endmodule

// ===== rtl/ddl_phase_detect.sv
// Purpose: sample the chain-versus-reference phase flag and pace updates
// Assumes: chain_lead comes from the analog sampler, asynchronous
// Notes:   upd pulses once every UPD_DIV cycles
`timescale 1ns/1ns
module ddl_phase_detect
  import ddl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic chain_lead,
  output logic      upd,
  output logic      up
);

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic [3:0] div;
    logic       upd;
    logic       up;
  } ddl_pd_state_t;

  ddl_pd_state_t s_q;
  ddl_pd_state_t s_d;

  always_comb begin
    s_d     = s_q;
    s_d.s1  = chain_lead;
    s_d.s2  = s_q.s1;
    s_d.upd = 1'b0;
    if (clear) begin
      s_d.div = 4'h0;
    end else if (s_q.div == UPD_DIV - 4'h1) begin
      s_d.div = 4'h0;
      s_d.upd = 1'b1;
      // chain output early: lengthen the delay
      s_d.up  = s_q.s2;
    end else begin
      s_d.div = s_q.div + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign upd = s_q.upd;
  assign up  = s_q.up;

endmodule

// ===== rtl/ddl_pkg.sv
// Purpose: shared constants, types and decode functions for the strobe
//          delay-locked loop controller
// Assumes: one clock, the selected reference clock, drives all logic
// Notes:   the analog delay chain and phase sampler sit outside this logic
package ddl_pkg;

  localparam int          DLY_W         = 6;
  localparam logic [5:0]  DLY_RST       = 6'h00;
  localparam logic [5:0]  DLY_MAX_FULL  = 6'h3F;
  localparam logic [5:0]  DLY_MAX_HALF  = 6'h1F;
  localparam logic [2:0]  MODE_HALF_LO  = 3'h4;
  localparam logic [10:0] LOCK_CYC_LJ   = 11'h500;
  localparam logic [10:0] LOCK_CYC_STD  = 11'h100;
  localparam logic [3:0]  UPD_DIV       = 4'h8;
  localparam logic [2:0]  MULT_MAX      = 3'h4;

  typedef enum logic [2:0] {
    ST_RESET   = 3'b001,
    ST_LOCKING = 3'b010,
    ST_LOCKED  = 3'b100
  } ddl_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic       low_jitter;
    logic       ref_from_pin;
    logic       ioe_resync_used;
    logic       qdr_mode;
    logic       phase_zero;
    logic [1:0] phase_mult;
    logic       offset_en;
    logic       offset_sub;
    logic [5:0] offset_mag;
  } ddl_cfg_t;

  typedef struct packed {
    logic [5:0] dly;
    logic       offset_en;
    logic       offset_sub;
    logic [5:0] offset_mag;
    logic [2:0] chain_steps;
    logic       bypass;
    logic       dq_clk_en;
    logic       cqn_neg_en;
  } ddl_strobe_t;

  typedef struct packed {
    logic [5:0] dly;
    logic       locked;
    logic       resync_en;
  } ddl_core_t;

  function automatic logic [4:0] ddl_chain_elems(input logic [2:0] m);
    logic [4:0] r;
    r = 5'h10;
    case (m)
      3'h0: r = 5'h10;
      3'h1: r = 5'h0C;
      3'h2: r = 5'h0A;
      3'h3: r = 5'h08;
      3'h4: r = 5'h0C;
      3'h5: r = 5'h0A;
      3'h6: r = 5'h08;
      default: r = 5'h06;
    endcase
    return r;
  endfunction

  // step in tenths of a degree
  function automatic logic [11:0] ddl_step_tenths(input logic [2:0] m);
    logic [11:0] r;
    r = 12'h0E1;
    case (m)
      3'h0: r = 12'h0E1;
      3'h1: r = 12'h12C;
      3'h2: r = 12'h168;
      3'h3: r = 12'h1C2;
      3'h4: r = 12'h12C;
      3'h5: r = 12'h168;
      3'h6: r = 12'h1C2;
      default: r = 12'h258;
    endcase
    return r;
  endfunction

  function automatic logic ddl_half_mode(input logic [2:0] m);
    return m >= MODE_HALF_LO;
  endfunction

endpackage
